// *** src/dpcr_top.sv ***
`timescale 1ns/1ps
module dpcr_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        sclk_i,
    input  wire logic                        cs_n_i,
    input  wire logic                        sdio_i,
    output logic                             sdio_o,
    output logic                             sdio_oe_o,
    input  wire logic [dpcr_pkg::BAND_W-1:0] cal_band_i,
    output logic [1:0]                       baseband_current_sel_o,
    output logic [1:0]                       gain_bandwidth_mode_o,
    output logic                             high_gain_o,
    output logic                             high_bandwidth_o,
    output logic [1:0]                       antibacklash_delay_o,
    output logic [2:0]                       pump_mode_o,
    output logic                             pump_up_en_o,
    output logic                             pump_down_en_o,
    output logic                             pump_tristate_o,
    output logic                             pump_normal_o,
    output logic [1:0]                       detector_edge_sel_o,
    output logic                             div_rising_o,
    output logic                             ref_rising_o,
    output logic                             dither_on_o,
    output logic [1:0]                       dither_magnitude_o,
    output logic                             dither_low_bit_o,
    output logic [15:0]                      dither_seed_value_o,
    output logic                             autocal_inhibit_o,
    output logic                             band_source_sel_o,
    output logic [dpcr_pkg::BAND_W-1:0]      band_field_o,
    output logic [dpcr_pkg::BAND_W-1:0]      band_readback_value_o,
    output logic [4:0]                       internal_set1_o,
    output logic [8:0]                       internal_set0_o
);

    localparam int DW = dpcr_pkg::DATA_W;

    dpcr_pins_if pins ();

    dpcr_pin_sync u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .sclk_i  (sclk_i),
        .cs_n_i  (cs_n_i),
        .sdio_i  (sdio_i),
        .pins    (pins)
    );

    // address decode, shared by the write and the read path
    function automatic logic [dpcr_pkg::IDX_W:0] decode(
        input logic [dpcr_pkg::ADDR_W-1:0] addr
    );
        logic [dpcr_pkg::IDX_W:0] r;
        r = '0;
        unique case (addr)
            dpcr_pkg::ADDR_BASEBAND: r = {1'b1, dpcr_pkg::IDX_BASEBAND};
            dpcr_pkg::ADDR_PHASE:    r = {1'b1, dpcr_pkg::IDX_PHASE};
            dpcr_pkg::ADDR_DITHER:   r = {1'b1, dpcr_pkg::IDX_DITHER};
            dpcr_pkg::ADDR_SEED:     r = {1'b1, dpcr_pkg::IDX_SEED};
            dpcr_pkg::ADDR_CALDIV:   r = {1'b1, dpcr_pkg::IDX_CALDIV};
            dpcr_pkg::ADDR_BANDCTL:  r = {1'b1, dpcr_pkg::IDX_BANDCTL};
            dpcr_pkg::ADDR_BANDRB:   r = {1'b1, dpcr_pkg::IDX_BANDRB};
            dpcr_pkg::ADDR_INTSET:   r = {1'b1, dpcr_pkg::IDX_INTSET};
            default:                 r = '0;
        endcase
        return r;
    endfunction

    dpcr_pkg::dpcr_state_t state_reg;
    logic [4:0]                    bit_cnt_reg;
    logic [DW-1:0]                 shift_in_reg;
    logic                          cmd_read_reg;
    logic [dpcr_pkg::IDX_W:0]      cmd_sel_reg;
    logic [DW-1:0]                 rd_shift_reg;
    logic [DW-1:0]                 regs_reg [dpcr_pkg::NUM_REGS];
    logic [dpcr_pkg::RB_W-1:0]     band_rb_reg;
    logic [dpcr_pkg::BAND_W-1:0]   band_next;
    logic [DW-1:0]                 wr_word;
    logic [dpcr_pkg::ADDR_W-1:0]   cmd_addr;
    logic [dpcr_pkg::IDX_W:0]      cmd_sel;
    logic                          cmd_is_read;
    logic                          cmd_end;
    logic                          data_end;
    logic                          wr_en;
    logic [DW-1:0]                 rd_word;

    // command byte completes on the eighth rising clock: read flag, then address
    assign cmd_is_read = shift_in_reg[6];
    assign cmd_addr    = {shift_in_reg[5:0], pins.sdi};
    assign cmd_sel     = decode(cmd_addr);
    assign cmd_end     = (state_reg == dpcr_pkg::ST_CMD) && pins.sclk_rise &&
                         (bit_cnt_reg == dpcr_pkg::CMD_LAST);
    assign data_end    = (state_reg == dpcr_pkg::ST_DATA) && pins.sclk_rise &&
                         (bit_cnt_reg == dpcr_pkg::DATA_LAST);
    assign wr_word     = {shift_in_reg[DW-2:0], pins.sdi};
    // a write to an unmapped address is dropped without any trace
    assign wr_en       = data_end && !cmd_read_reg && cmd_sel_reg[dpcr_pkg::IDX_W];

    // frame sequencer; chip select going away ends a frame anywhere
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg   <= dpcr_pkg::ST_IDLE;
            bit_cnt_reg <= 5'h00;
        end else if (!pins.cs_active) begin
            state_reg   <= dpcr_pkg::ST_IDLE;
            bit_cnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                dpcr_pkg::ST_IDLE: begin
                    // a clock of margin after select, before bits count
                    state_reg   <= dpcr_pkg::ST_CMD;
                    bit_cnt_reg <= 5'h00;
                end
                dpcr_pkg::ST_CMD: begin
                    if (cmd_end) begin
                        state_reg   <= dpcr_pkg::ST_DATA;
                        bit_cnt_reg <= 5'h00;
                    end else if (pins.sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                dpcr_pkg::ST_DATA: begin
                    if (data_end) begin
                        state_reg <= dpcr_pkg::ST_DONE;
                    end else if (pins.sclk_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                dpcr_pkg::ST_DONE: begin
                    // clocks beyond the frame are ignored until deselect
                    state_reg <= dpcr_pkg::ST_DONE;
                end
            endcase
        end
    end

    // input shifter, msb first on rising clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            shift_in_reg <= '0;
        end else if (!pins.cs_active) begin
            shift_in_reg <= '0;
        end else if (pins.sclk_rise && (state_reg == dpcr_pkg::ST_CMD ||
                                        state_reg == dpcr_pkg::ST_DATA)) begin
            shift_in_reg <= wr_word;
        end
    end

    // command latch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_read_reg <= 1'b0;
            cmd_sel_reg  <= '0;
        end else if (cmd_end) begin
            cmd_read_reg <= cmd_is_read;
            cmd_sel_reg  <= cmd_sel;
        end
    end

    // read word picked while the command byte closes
    // unmapped offsets fall through to zero, so a stray read shows a quiet line
    always_comb begin
        rd_word = '0;
        if (cmd_sel[dpcr_pkg::IDX_W]) begin
            if (cmd_sel[dpcr_pkg::IDX_W-1:0] == dpcr_pkg::IDX_BANDRB) begin
                rd_word = {{(DW-dpcr_pkg::RB_W){1'b0}}, band_rb_reg};
            end else begin
                rd_word = regs_reg[cmd_sel[dpcr_pkg::IDX_W-1:0]];
            end
        end
    end

    // read data leaves on falling clocks so the host can sample on rising ones
    // the line is let go after the last bit, before the host may drive again
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_shift_reg <= '0;
            sdio_o       <= 1'b0;
            sdio_oe_o    <= 1'b0;
        end else if (!pins.cs_active || state_reg == dpcr_pkg::ST_DONE &&
                     pins.sclk_fall) begin
            rd_shift_reg <= '0;
            sdio_o       <= 1'b0;
            sdio_oe_o    <= 1'b0;
        end else if (cmd_end && cmd_is_read) begin
            rd_shift_reg <= rd_word;
        end else if (pins.sclk_fall && state_reg == dpcr_pkg::ST_DATA &&
                     cmd_read_reg) begin
            sdio_o       <= rd_shift_reg[DW-1];
            sdio_oe_o    <= 1'b1;
            rd_shift_reg <= {rd_shift_reg[DW-2:0], 1'b0};
        end
    end

    // storage: only the documented bits keep what is written
    genvar g;
    generate
        for (g = 0; g < dpcr_pkg::NUM_REGS; g++) begin : g_reg
            // slot number at the index width, matched against the latched decode
            localparam logic [dpcr_pkg::IDX_W-1:0] SLOT = (dpcr_pkg::IDX_W)'(g);
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    regs_reg[g] <= dpcr_pkg::REG_RESET[g];
                end else if (wr_en &&
                             cmd_sel_reg[dpcr_pkg::IDX_W-1:0] == SLOT) begin
                    regs_reg[g] <= wr_word & dpcr_pkg::REG_MASK[g];
                end
            end
        end
    endgenerate

    // internal settings are stored as written; sequencing them is the host's job
    assign internal_set1_o = regs_reg[dpcr_pkg::IDX_INTSET][dpcr_pkg::SET1_LSB +: 5];
    assign internal_set0_o = regs_reg[dpcr_pkg::IDX_INTSET][dpcr_pkg::SET0_LSB +: 9];

    // raw fields drive the analog side straight from storage
    assign baseband_current_sel_o =
        regs_reg[dpcr_pkg::IDX_BASEBAND][dpcr_pkg::BASEBAND_CURRENT_SEL_LSB +: 2];
    assign gain_bandwidth_mode_o =
        regs_reg[dpcr_pkg::IDX_BASEBAND][dpcr_pkg::BW_MODE_LSB +: 2];
    assign antibacklash_delay_o = regs_reg[dpcr_pkg::IDX_PHASE][dpcr_pkg::ABL_LSB +: 2];
    assign pump_mode_o          = regs_reg[dpcr_pkg::IDX_PHASE][dpcr_pkg::PUMP_LSB +: 3];
    assign detector_edge_sel_o  = regs_reg[dpcr_pkg::IDX_PHASE][dpcr_pkg::EDGE_LSB +: 2];
    assign dither_on_o          = regs_reg[dpcr_pkg::IDX_DITHER][dpcr_pkg::DITH_ON_BIT];
    assign dither_magnitude_o   =
        regs_reg[dpcr_pkg::IDX_DITHER][dpcr_pkg::DITHER_MAGNITUDE_LSB +: 2];
    assign dither_low_bit_o     = regs_reg[dpcr_pkg::IDX_DITHER][dpcr_pkg::DITH_LOW_BIT];
    assign dither_seed_value_o  = regs_reg[dpcr_pkg::IDX_SEED];
    assign autocal_inhibit_o    =
        regs_reg[dpcr_pkg::IDX_CALDIV][dpcr_pkg::AUTOCAL_BIT];
    assign band_source_sel_o    = regs_reg[dpcr_pkg::IDX_BANDCTL][dpcr_pkg::BAND_SRC_BIT];
    assign band_field_o         =
        regs_reg[dpcr_pkg::IDX_BANDCTL][dpcr_pkg::BAND_LSB +: dpcr_pkg::BAND_W];

    // decoded gain and bandwidth: high bit picks low gain, low bit low bandwidth
    // registered so the analog side sees one clean change per write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            high_gain_o      <= 1'b0;
            high_bandwidth_o <= 1'b0;
        end else begin
            high_gain_o      <= ~gain_bandwidth_mode_o[1];
            high_bandwidth_o <= ~gain_bandwidth_mode_o[0];
        end
    end

    // pump forcing; undefined codes fall back to normal detector action,
    // which is the least disruptive state for a loop that may be locked
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pump_up_en_o    <= 1'b0;
            pump_down_en_o  <= 1'b0;
            pump_tristate_o <= 1'b0;
            pump_normal_o   <= 1'b1;
        end else begin
            pump_up_en_o    <= (pump_mode_o == dpcr_pkg::PUMP_BOTH) ||
                               (pump_mode_o == dpcr_pkg::PUMP_UP);
            pump_down_en_o  <= (pump_mode_o == dpcr_pkg::PUMP_BOTH) ||
                               (pump_mode_o == dpcr_pkg::PUMP_DOWN);
            pump_tristate_o <= (pump_mode_o == dpcr_pkg::PUMP_TRI);
            pump_normal_o   <= (pump_mode_o >= dpcr_pkg::PUMP_PFD);
        end
    end

    // edge choice: bit one for the divider, bit zero for the reference
    // follows the stored code one clock late, like the pump decode
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_rising_o <= 1'b0;
            ref_rising_o <= 1'b0;
        end else begin
            div_rising_o <= detector_edge_sel_o[1];
            ref_rising_o <= detector_edge_sel_o[0];
        end
    end

    // band mux: serial field when the source bit is clear, calibration otherwise
    // the calibration engine shares this clock, so its band needs no synchroniser
    assign band_next = band_source_sel_o ? cal_band_i : band_field_o;

    // registered mux and a readback copy of its low six bits, one cycle behind the inputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            band_readback_value_o  <= '0;
            band_rb_reg <= '0;
        end else begin
            band_readback_value_o  <= band_next;
            band_rb_reg <= band_next[dpcr_pkg::RB_W-1:0];
        end
    end

endmodule // dpcr_top

// *** common/dpcr_pkg.sv ***
package dpcr_pkg;

    // frame layout of the 3-wire serial port
    localparam int ADDR_W      = 7;
    localparam int DATA_W      = 16;
    localparam int CMD_BITS    = 8;
    localparam int NUM_REGS    = 8;
    localparam int IDX_W       = 3;
    localparam int SYNC_STAGES = 3;
    localparam int BAND_W      = 7;
    localparam int RB_W        = 6;
    localparam logic [4:0] CMD_LAST  = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    // register offsets
    localparam logic [ADDR_W-1:0] ADDR_BASEBAND = 7'h34;
    localparam logic [ADDR_W-1:0] ADDR_PHASE    = 7'h40;
    localparam logic [ADDR_W-1:0] ADDR_DITHER   = 7'h42;
    localparam logic [ADDR_W-1:0] ADDR_SEED     = 7'h43;
    localparam logic [ADDR_W-1:0] ADDR_CALDIV   = 7'h44;
    localparam logic [ADDR_W-1:0] ADDR_BANDCTL  = 7'h45;
    localparam logic [ADDR_W-1:0] ADDR_BANDRB   = 7'h46;
    localparam logic [ADDR_W-1:0] ADDR_INTSET   = 7'h49;

    // storage indices
    localparam logic [IDX_W-1:0] IDX_BASEBAND = 3'h0;
    localparam logic [IDX_W-1:0] IDX_PHASE    = 3'h1;
    localparam logic [IDX_W-1:0] IDX_DITHER   = 3'h2;
    localparam logic [IDX_W-1:0] IDX_SEED     = 3'h3;
    localparam logic [IDX_W-1:0] IDX_CALDIV   = 3'h4;
    localparam logic [IDX_W-1:0] IDX_BANDCTL  = 3'h5;
    localparam logic [IDX_W-1:0] IDX_BANDRB   = 3'h6;
    localparam logic [IDX_W-1:0] IDX_INTSET   = 3'h7;

    // writable bits per index, index 7 first; read-only readback has none
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_MASK = {
        16'h3fff, 16'h0000, 16'h00ff, 16'h0001,
        16'hffff, 16'h000f, 16'h007f, 16'h0f00};
    localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
        16'h16bd, 16'h0000, 16'h0000, 16'h0000,
        16'h0001, 16'h000e, 16'h0010, 16'h0b00};

    // field positions
    localparam int BASEBAND_CURRENT_SEL_LSB  = 10;
    localparam int BW_MODE_LSB  = 8;
    localparam int ABL_LSB      = 5;
    localparam int PUMP_LSB     = 2;
    localparam int EDGE_LSB     = 0;
    localparam int DITH_ON_BIT  = 3;
    localparam int DITHER_MAGNITUDE_LSB = 1;
    localparam int DITH_LOW_BIT = 0;
    localparam int AUTOCAL_BIT  = 0;
    localparam int BAND_SRC_BIT = 7;
    localparam int BAND_LSB     = 0;
    localparam int SET1_LSB     = 9;
    localparam int SET0_LSB     = 0;

    // pump mode codes
    localparam logic [2:0] PUMP_BOTH = 3'h0;
    localparam logic [2:0] PUMP_DOWN = 3'h1;
    localparam logic [2:0] PUMP_UP   = 3'h2;
    localparam logic [2:0] PUMP_TRI  = 3'h3;
    localparam logic [2:0] PUMP_PFD  = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CMD,
        ST_DATA,
        ST_DONE
    } dpcr_state_t;

endpackage

// *** common/dpcr_pins_if.sv ***
`timescale 1ns/1ps
// cleaned serial-port events handed from the pin front end to the bank
interface dpcr_pins_if;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_active;
    logic sdi;

    modport producer (
        output sclk_rise,
        output sclk_fall,
        output cs_active,
        output sdi
    );
    modport consumer (
        input sclk_rise,
        input sclk_fall,
        input cs_active,
        input sdi
    );
endinterface

// *** src/dpcr_pin_sync.sv ***
`timescale 1ns/1ps
module dpcr_pin_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic sclk_i,
    input  wire logic cs_n_i,
    input  wire logic sdio_i,
    dpcr_pins_if.producer pins
);
    localparam int NP = 3;

    logic [NP-1:0] raw;
    logic [NP-1:0] filt_reg;
    logic          sclk_prev_reg;

    assign raw = {sdio_i, cs_n_i, sclk_i};

    // three stages per pin; the level moves only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_pin
            logic [dpcr_pkg::SYNC_STAGES-1:0] sync_reg;
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    sync_reg <= (g == 1) ? '1 : '0; // select idles high: no false frame
                end else begin
                    sync_reg <= {sync_reg[dpcr_pkg::SYNC_STAGES-2:0], raw[g]};
                end
            end
            // stage one feeds stage two only; the filter looks at two and three
            always_ff @(posedge clk_i) begin
                if (!rst_n_i) begin
                    filt_reg[g] <= (g == 1) ? 1'b1 : 1'b0;
                end else if (sync_reg[1] == sync_reg[2]) begin
                    filt_reg[g] <= sync_reg[2];
                end
            end
        end
    endgenerate

    // clock edges taken from the filtered level
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= filt_reg[0];
        end
    end

    assign pins.sclk_rise = filt_reg[0] & ~sclk_prev_reg;
    assign pins.sclk_fall = ~filt_reg[0] & sclk_prev_reg;
    assign pins.cs_active = ~filt_reg[1];
    assign pins.sdi       = filt_reg[2];

endmodule // dpcr_pin_sync

// *** tb/dpcr_monitor.sv ***
`timescale 1ns/1ps
// watches the decoded outputs against the stored fields that feed them
module dpcr_monitor (
    input wire logic                        clk_i,
    input wire logic                        rst_n_i,
    input wire logic                        cs_n_i,
    input wire logic                        sdio_oe_o,
    input wire logic [dpcr_pkg::BAND_W-1:0] cal_band_i,
    input wire logic [1:0]                  gain_bandwidth_mode_o,
    input wire logic                        high_gain_o,
    input wire logic                        high_bandwidth_o,
    input wire logic [2:0]                  pump_mode_o,
    input wire logic                        pump_up_en_o,
    input wire logic                        pump_down_en_o,
    input wire logic                        pump_tristate_o,
    input wire logic                        pump_normal_o,
    input wire logic [1:0]                  detector_edge_sel_o,
    input wire logic                        div_rising_o,
    input wire logic                        ref_rising_o,
    input wire logic                        autocal_inhibit_o,
    input wire logic                        band_source_sel_o,
    input wire logic [dpcr_pkg::BAND_W-1:0] band_field_o,
    input wire logic [dpcr_pkg::BAND_W-1:0] band_readback_value_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // port idle long enough that the synchroniser has flushed any frame
    sequence s_cs_idle;
        cs_n_i [*8];
    endsequence

    a_reset_values: assert property ($rose(rst_n_i) |->
        gain_bandwidth_mode_o == 2'h3 && pump_mode_o == 3'h4 && detector_edge_sel_o == 2'h0
        && !autocal_inhibit_o && !band_source_sel_o && band_readback_value_o == 7'h00)
        else $error("fields not at reset values after reset");
    a_gain_map: assert property (high_gain_o == !$past(gain_bandwidth_mode_o[1])
        && high_bandwidth_o == !$past(gain_bandwidth_mode_o[0]))
        else $error("gain or bandwidth decode wrong");
    a_pump_decode: assert property (
        pump_up_en_o == ($past(pump_mode_o) == 3'h0 || $past(pump_mode_o) == 3'h2)
        && pump_down_en_o == ($past(pump_mode_o) == 3'h0 || $past(pump_mode_o) == 3'h1)
        && pump_tristate_o == ($past(pump_mode_o) == 3'h3)
        && pump_normal_o == $past(pump_mode_o[2]))
        else $error("pump mode decode wrong");
    a_pump_exclusive: assert property (pump_tristate_o |->
        !pump_up_en_o && !pump_down_en_o && !pump_normal_o)
        else $error("tristate pump combined with a drive");
    a_edge_decode: assert property ($past(detector_edge_sel_o) == {div_rising_o, ref_rising_o})
        else $error("edge select decode wrong");
    a_band_mux: assert property (
        band_readback_value_o == ($past(band_source_sel_o) ? $past(cal_band_i) : $past(band_field_o)))
        else $error("band mux picks wrong source");
    a_fields_stable: assert property (s_cs_idle |=> $stable({gain_bandwidth_mode_o,
        pump_mode_o, detector_edge_sel_o, autocal_inhibit_o, band_source_sel_o, band_field_o}))
        else $error("field changed with the port idle");
    a_oe_idle: assert property (s_cs_idle |-> !sdio_oe_o)
        else $error("data line driven with the port idle");
endmodule // dpcr_monitor

bind dpcr_top dpcr_monitor u_monitor (.*);

// *** tb/dpcr_host.sv ***
`timescale 1ns/1ps
// host side of the 3-wire port; sclk idles low and only moves inside frames
module dpcr_host (
    input  wire logic clk_i,
    input  wire logic sdio_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdio_o
);
    localparam int HALF = 10;  // each sclk phase outlasts the 8-cycle minimum
    logic bit_q = 1'b0;
    logic drv_q = 1'b0;
    logic tog_q = 1'b0;

    // a released line shows a changing pattern, never the last bit
    always @(posedge clk_i) tog_q <= ~tog_q;
    assign sdio_o = drv_q ? bit_q : tog_q;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end

    // one frame: command byte then data word, bits put out on falling sclk;
    // a count below 24 leaves the frame short so the device must drop it
    task automatic xfer(input logic rw, input logic [6:0] a, input logic [15:0] d,
                        input int nbits, output logic [15:0] q);
        logic [23:0] w;
        w = {rw, a, d};
        q = 16'h0000;
        cs_n_o <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b0;
            bit_q <= w[23-i];
            drv_q <= !(rw && i >= 8);
            repeat (HALF) @(posedge clk_i);
            sclk_o <= 1'b1;
            if (i >= 8) q = {q[14:0], sdio_i};
        end
        repeat (HALF) @(posedge clk_i);
        sclk_o <= 1'b0;
        drv_q <= 1'b0;
        repeat (HALF) @(posedge clk_i);
        cs_n_o <= 1'b1;
        repeat (HALF) @(posedge clk_i);
    endtask
endmodule // dpcr_host

// *** tb/dpcr_top_tb.sv ***
`timescale 1ns/1ps
module dpcr_top_tb;
    // offsets, reset values and writable bits, offset 0x34 last in each list
    localparam logic [7:0][6:0]  ADR = {7'h49, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h40, 7'h34};
    localparam logic [7:0][15:0] RST = {16'h16bd, 16'h0000, 16'h0000, 16'h0000,
                                        16'h0001, 16'h000e, 16'h0010, 16'h0b00};
    localparam logic [7:0][15:0] MSK = {16'h3fff, 16'h0000, 16'h00ff, 16'h0001,
                                        16'hffff, 16'h000f, 16'h007f, 16'h0f00};
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        sclk, cs_n, host_sdio, sdio_w, dev_sdio, dev_oe;
    logic [6:0]  cal_band = 7'h00;
    logic [6:0]  vband;
    logic [1:0]  mode, edge_sel;
    logic [2:0]  pump;
    logic        hg, hb, up, dn, tri_s, nrm, div_r, ref_r, acal, bsrc;
    logic [15:0] rq;
    logic [1:0]  bbc, abl, dmag;
    logic        don, dlow;
    logic [15:0] seed;
    logic [6:0]  bfld;
    logic [4:0]  set1;
    logic [8:0]  set0;
    int          fail_count = 0;
    int          cmp_count = 0;

    always #2.5 clk_i = ~clk_i;
    // the wire follows whichever side has it enabled
    assign sdio_w = dev_oe ? dev_sdio : host_sdio;

    dpcr_host host (.clk_i(clk_i), .sdio_i(sdio_w), .sclk_o(sclk), .cs_n_o(cs_n),
                    .sdio_o(host_sdio));
    dpcr_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdio_i(sdio_w), .sdio_o(dev_sdio), .sdio_oe_o(dev_oe), .cal_band_i(cal_band),
        .baseband_current_sel_o(bbc), .gain_bandwidth_mode_o(mode), .high_gain_o(hg),
        .high_bandwidth_o(hb), .antibacklash_delay_o(abl), .pump_mode_o(pump),
        .pump_up_en_o(up), .pump_down_en_o(dn), .pump_tristate_o(tri_s),
        .pump_normal_o(nrm), .detector_edge_sel_o(edge_sel), .div_rising_o(div_r),
        .ref_rising_o(ref_r), .dither_on_o(don), .dither_magnitude_o(dmag),
        .dither_low_bit_o(dlow), .dither_seed_value_o(seed), .autocal_inhibit_o(acal),
        .band_source_sel_o(bsrc), .band_field_o(bfld), .band_readback_value_o(vband),
        .internal_set1_o(set1), .internal_set0_o(set0));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer(1'b0, a, d, 24, rq);
    endtask
    task rd(input logic [6:0] a);
        host.xfer(1'b1, a, 16'h0000, 24, rq);
    endtask

    // every register at its reset value, an unmapped offset reads zero
    task t_reset;
        for (int i = 0; i < 8; i++) begin
            rd(ADR[i]);
            chk(rq, RST[i]);
        end
        rd(7'h35);
        chk(rq, 16'h0000);
        chk({bbc, abl, dmag, don, dlow, 8'h00}, {2'h2, 2'h0, 2'h3, 1'b1, 1'b0, 8'h00});
        chk(seed, 16'h0001);
        chk({set1, set0, 2'h0}, {5'h0b, 9'h0bd, 2'h0});
    endtask
    // all four gain and bandwidth pairs, with stray bits that must not stick
    task t_mode;
        for (int m = 0; m < 4; m++) begin
            wr(7'h34, {4'h0, 2'h3, m[1:0], 8'hff});
            chk({12'h000, mode, hg, hb}, {12'h000, m[1:0], !m[1], !m[0]});
            rd(7'h34);
            chk(rq, {4'h0, 2'h3, m[1:0], 8'h00});
        end
    endtask
    // each pump code, the edge field sweeping all four codes alongside
    task t_pump;
        logic [2:0] c;
        for (int i = 0; i < 5; i++) begin
            c = i[2:0];
            wr(7'h40, {9'h000, 2'h2, c, c[1:0]});
            chk({13'h0000, pump}, {13'h0000, c});
            chk({10'h000, up, dn, tri_s, nrm, div_r, ref_r}, {10'h000, (c == 3'h0 || c == 3'h2),
                (c == 3'h0 || c == 3'h1), (c == 3'h3), c[2], c[1:0]});
            rd(7'h40);
            chk(rq, {9'h000, 2'h2, c, c[1:0]});
        end
    endtask
    // calibration inhibit, both band sources, readback ignores writes
    task t_band;
        wr(7'h44, 16'hffff);
        chk({15'h0000, acal}, 16'h0001);
        wr(7'h44, 16'h0000);
        chk({15'h0000, acal}, 16'h0000);
        cal_band <= 7'h55;
        wr(7'h45, 16'h002a);
        chk({8'h00, bsrc, vband}, 16'h002a);
        chk({9'h000, bfld}, 16'h002a);
        rd(7'h46);
        chk(rq, 16'h002a);
        wr(7'h45, 16'h0080);
        chk({8'h00, bsrc, vband}, 16'h00d5);
        wr(7'h46, 16'hffff);
        rd(7'h46);
        chk(rq, 16'h0015);
    endtask
    // all ones into every writable register keep only the listed bits
    task t_mask;
        for (int i = 0; i < 8; i++) begin
            if (i != 6) begin
                wr(ADR[i], 16'hffff);
                rd(ADR[i]);
                chk(rq, MSK[i]);
            end
        end
        chk({bbc, abl, dmag, don, dlow, 8'h00}, 16'hff00);
        chk(seed, 16'hffff);
        chk({set1, set0, 2'h0}, 16'hfffc);
    endtask
    // a short frame changes nothing; settings word restored afterwards
    task t_abort;
        logic [15:0] q;
        wr(7'h43, 16'h1234);
        host.xfer(1'b0, 7'h43, 16'hbeef, 20, q);
        rd(7'h43);
        chk(rq, 16'h1234);
        wr(7'h49, 16'h16bd);
        rd(7'h49);
        chk(rq, 16'h16bd);
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // 53 frames of at most 510 cycles each fit well inside this span
    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        give_verdict;
    end

    initial begin
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        t_reset;
        t_mode;
        t_pump;
        t_band;
        t_mask;
        t_abort;
        give_verdict;
    end
endmodule // dpcr_top_tb
